// *** srcf_pkg.sv ***
// package for service request and receive character filter
// shared by the filter core; no surroundings assumed
package srcf_pkg;
    localparam logic [1:0] REG_ERRORS  = 2'h0;
    localparam logic [1:0] REG_BUFFERS = 2'h1;
    localparam logic [1:0] REG_EVENTS  = 2'h2;
    localparam logic [1:0] REG_DELETE  = 2'h3;
    localparam int BIT_MASTER    = 3;
    localparam int BIT_DATA_ERR  = 2;
    localparam int BIT_OVERFLOW  = 0;
    localparam int BIT_RX_FULL   = 3;
    localparam int BIT_RX_AVAIL  = 2;
    localparam int BIT_TX_ROOM   = 1;
    localparam int BIT_TX_EMPTY  = 0;
    localparam int BIT_MANUAL    = 2;
    localparam int BIT_AUTODISC  = 1;
    localparam int BIT_BREAK     = 0;
    localparam int BIT_DEL_DEL   = 2;
    localparam int BIT_DEL_NUL   = 1;
    localparam int BIT_DEL_SEL   = 0;
    localparam logic [3:0] USED_ERRORS  = 4'hd;
    localparam logic [3:0] USED_BUFFERS = 4'hf;
    localparam logic [3:0] USED_EVENTS  = 4'h7;
    localparam logic [3:0] USED_DELETE  = 4'h7;
    localparam logic [3:0] RST_CLOSED      = 4'h0;
    localparam logic [3:0] RST_OPEN_ERRORS = 4'hd;
    localparam logic [3:0] RST_OPEN_BUFFER = 4'h5;
    localparam logic [3:0] RST_OPEN_EVENTS = 4'h2;
    localparam logic [7:0] CHAR_DEL      = 8'h7f;
    localparam logic [7:0] CHAR_NUL      = 8'h00;
    localparam logic [7:0] RST_SEL_CHAR  = 8'h00;
endpackage

// *** srcf_core.sv ***
// service request enables and receive character deletion core
// assumes a loop decoder presents register writes as one-cycle strobes on core_clk
//
// Contract
// R1: no service request unless master request enable is set.
// R2: data error enable flags parity, framing, overrun, buffer overflow errors.
// R3: overflow enable flags data discarded because receive buffer was full.
// R4: receive-full enable flags request while receive buffer is full.
// R5: receive-not-empty enable flags request while receive buffer holds data.
// R6: transmit-not-full enable flags request while transmit buffer has room.
// R7: transmit-empty enable flags request while transmit buffer is empty.
// R8: manual enable flags request while manual request key is pressed.
// R9: autodisconnect enable flags request while link stopped by autodisconnect.
// R10: break enable flags request while break is detected on receive line.
// R11: unused register bits have no function and read as zero.
// R12: delete enable drops received code 127 before forwarding.
// R13: null enable drops received code 0 before forwarding.
// R14: selectable enable drops characters equal to the selectable delete register.
// R15: with request switch closed all four registers default to zero.
// R16: with switch open request registers default to 1101, 0101, 0010.
// R17: power-up and reset key reload all registers with defaults.
// R18: controller writes a register with listener 0 message plus data byte.
// R19: pending request is master enable and OR of enabled conditions.
// R20: deletions are applied before the character enters the receive buffer.
`timescale 1ns/1ps
module srcf_core
    import srcf_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       reset_key,
    input  wire logic       request_switch_open,
    input  wire logic       reg_wr,
    input  wire logic [1:0] reg_sel,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       sel_char_wr,
    input  wire logic [7:0] sel_char_wdata,
    input  wire logic [1:0] rd_sel,
    output logic      [3:0] rd_data,
    input  wire logic       parity_err,
    input  wire logic       framing_err,
    input  wire logic       overrun_err,
    input  wire logic       rx_overflow,
    input  wire logic       rx_full,
    input  wire logic       rx_not_empty,
    input  wire logic       tx_not_full,
    input  wire logic       tx_empty,
    input  wire logic       manual_request_key,
    input  wire logic       autodisconnect,
    input  wire logic       break_detect,
    input  wire logic       rx_char_valid,
    input  wire logic [7:0] rx_char,
    output logic            rxbuf_wr,
    output logic      [7:0] rxbuf_wdata,
    output logic            service_request
);
    import srcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers for pins
    logic [1:0] key_s1_q, key_s2_q;
    // pins pass two flops before any logic reads them
    logic       sw_s1_q, sw_s2_q;
    logic       brk_s1_q, brk_s2_q;
    logic       key_prev_q;
    // power-up load waits for the switch synchroniser to fill
    logic [2:0] init_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            key_s1_q   <= 2'h0;
            key_s2_q   <= 2'h0;
            sw_s1_q    <= 1'b0;
            sw_s2_q    <= 1'b0;
            brk_s1_q   <= 1'b0;
            brk_s2_q   <= 1'b0;
            key_prev_q <= 1'b0;
            init_q     <= 3'h7;
        end else begin
            key_s1_q   <= {manual_request_key, reset_key};
            key_s2_q   <= key_s1_q;
            sw_s1_q    <= request_switch_open;
            sw_s2_q    <= sw_s1_q;
            brk_s1_q   <= break_detect;
            brk_s2_q   <= brk_s1_q;
            key_prev_q <= key_s2_q[0];
            init_q     <= {init_q[1:0], 1'b0};
        end
    end

    wire manual_sync = key_s2_q[1];
    wire switch_open = sw_s2_q;
    wire break_sync  = brk_s2_q;
    // defaults reloaded after power-up release and on reset key press
    // power-up load lands on the third edge, once the switch is seen
    wire init_load     = init_q[2] & ~init_q[1]; // R17
    wire key_press     = key_s2_q[0] & ~key_prev_q; // R17
    wire load_defaults = init_load | key_press; // R17

    ////////////////////////////////////////////////////////////////////////
    // control registers
    logic [3:0] req_errors_q, req_buffers_q, req_events_q, del_ctrl_q;
    logic [7:0] sel_char_q;

    wire [3:0] dflt_errors  = switch_open ? RST_OPEN_ERRORS : RST_CLOSED; // R15 R16
    wire [3:0] dflt_buffers = switch_open ? RST_OPEN_BUFFER : RST_CLOSED; // R15 R16
    wire [3:0] dflt_events  = switch_open ? RST_OPEN_EVENTS : RST_CLOSED; // R15 R16

    // write strobes from the listener 0 message decoder
    wire wr_errors  = reg_wr & (reg_sel == REG_ERRORS); // R18
    wire wr_buffers = reg_wr & (reg_sel == REG_BUFFERS);
    wire wr_events  = reg_wr & (reg_sel == REG_EVENTS);
    wire wr_delete  = reg_wr & (reg_sel == REG_DELETE);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_errors_q  <= RST_CLOSED;
            req_buffers_q <= RST_CLOSED;
            req_events_q  <= RST_CLOSED;
            del_ctrl_q    <= RST_CLOSED;
            sel_char_q    <= RST_SEL_CHAR;
        end else if (load_defaults) begin
            req_errors_q  <= dflt_errors;
            req_buffers_q <= dflt_buffers;
            req_events_q  <= dflt_events;
            del_ctrl_q    <= RST_CLOSED;
            sel_char_q    <= RST_SEL_CHAR;
        end else begin
            // unused bits never stored
            if (wr_errors)   req_errors_q  <= reg_wdata[3:0] & USED_ERRORS; // R11
            if (wr_buffers)  req_buffers_q <= reg_wdata[3:0] & USED_BUFFERS;
            if (wr_events)   req_events_q  <= reg_wdata[3:0] & USED_EVENTS; // R11
            if (wr_delete)   del_ctrl_q    <= reg_wdata[3:0] & USED_DELETE; // R11
            if (sel_char_wr) sel_char_q    <= sel_char_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register readback
    wire [3:0] rd_mux = (rd_sel == REG_ERRORS)  ? req_errors_q  :
                        (rd_sel == REG_BUFFERS) ? req_buffers_q :
                        (rd_sel == REG_EVENTS)  ? req_events_q  : del_ctrl_q;

    ////////////////////////////////////////////////////////////////////////
    // service request conditions
    wire any_data_err = parity_err | framing_err | overrun_err | rx_overflow;
    wire cond_data_err = req_errors_q[BIT_DATA_ERR] & any_data_err; // R2
    wire cond_overflow = req_errors_q[BIT_OVERFLOW] & rx_overflow; // R3
    wire cond_rx_full  = req_buffers_q[BIT_RX_FULL] & rx_full; // R4
    wire cond_rx_avail = req_buffers_q[BIT_RX_AVAIL] & rx_not_empty; // R5
    wire cond_tx_room  = req_buffers_q[BIT_TX_ROOM] & tx_not_full; // R6
    wire cond_tx_empty = req_buffers_q[BIT_TX_EMPTY] & tx_empty; // R7
    wire cond_manual   = req_events_q[BIT_MANUAL] & manual_sync; // R8
    wire cond_autodisc = req_events_q[BIT_AUTODISC] & autodisconnect; // R9
    wire cond_break    = req_events_q[BIT_BREAK] & break_sync; // R10

    wire any_cond = cond_data_err | cond_overflow | cond_rx_full | cond_rx_avail |
                    cond_tx_room | cond_tx_empty | cond_manual | cond_autodisc |
                    cond_break; // R19
    wire master_request_enable = req_errors_q[BIT_MASTER];
    wire srq_d = master_request_enable & any_cond; // R1 R19

    ////////////////////////////////////////////////////////////////////////
    // receive character deletion ahead of the receive buffer
    function automatic logic char_match(input logic en, input logic [7:0] a,
                                        input logic [7:0] b);
        char_match = en & (a == b);
    endfunction

    wire drop_char = char_match(del_ctrl_q[BIT_DEL_DEL], rx_char, CHAR_DEL)   // R12
                   | char_match(del_ctrl_q[BIT_DEL_NUL], rx_char, CHAR_NUL)   // R13
                   | char_match(del_ctrl_q[BIT_DEL_SEL], rx_char, sel_char_q); // R14
    wire fwd_char  = rx_char_valid & ~drop_char; // R20

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            service_request <= 1'b0;
            rxbuf_wr        <= 1'b0;
            rxbuf_wdata     <= 8'h00;
            rd_data         <= 4'h0;
        end else begin
            service_request <= srq_d;
            rxbuf_wr        <= fwd_char;
            rxbuf_wdata     <= fwd_char ? rx_char : rxbuf_wdata;
            rd_data         <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // selectable character seen while its delete bit is set
    sequence s_char_drop;
        rx_char_valid && del_ctrl_q[BIT_DEL_SEL] && rx_char == sel_char_q;
    endsequence

    // reset key edge after the synchroniser
    sequence s_key_press;
        key_s2_q[0] && !key_prev_q;
    endsequence

    // power-up load after the switch synchroniser has filled
    sequence s_init_load;
        init_q[2] && !init_q[1];
    endsequence

    master_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
        !master_request_enable |=> !service_request)
        else $error("request sent without master enable");

    data_err_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
        (master_request_enable && req_errors_q[BIT_DATA_ERR] && parity_err) |=> service_request)
        else $error("parity error raised no request");

    overflow_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
        (req_errors_q == 4'h9 && rx_overflow) |=> service_request)
        else $error("overflow raised no request");

    buffers_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
        (master_request_enable && cond_rx_full) |=> service_request)
        else $error("receive full raised no request");

    tx_empty_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
        (master_request_enable && req_buffers_q[BIT_TX_EMPTY] && tx_empty) |=> service_request)
        else $error("transmit empty raised no request");

    unused_bits_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
        req_errors_q[1] == 1'b0 && req_events_q[3] == 1'b0 && del_ctrl_q[3] == 1'b0)
        else $error("unused bit stored");

    del_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
        (rx_char_valid && del_ctrl_q[BIT_DEL_DEL] && rx_char == CHAR_DEL) |=> !rxbuf_wr)
        else $error("delete character forwarded");

    nul_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
        (rx_char_valid && del_ctrl_q[BIT_DEL_NUL] && rx_char == CHAR_NUL) |=> !rxbuf_wr)
        else $error("null character forwarded");

    sel_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
        s_char_drop |=> !rxbuf_wr)
        else $error("selected character forwarded");

    keep_char_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
        (rx_char_valid && !drop_char) |=> (rxbuf_wr && rxbuf_wdata == $past(rx_char)))
        else $error("kept character not forwarded");

    defaults_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R16
        (load_defaults && switch_open) |=> (req_errors_q == 4'hd && req_buffers_q == 4'h5
                                           && req_events_q == 4'h2 && del_ctrl_q == 4'h0))
        else $error("open switch defaults wrong");

    closed_dflt_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
        (load_defaults && !switch_open) |=> (req_errors_q == 4'h0 && req_buffers_q == 4'h0
                                            && req_events_q == 4'h0 && del_ctrl_q == 4'h0))
        else $error("closed switch defaults wrong");

    key_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R17
        s_key_press |=> (del_ctrl_q == RST_CLOSED && sel_char_q == RST_SEL_CHAR))
        else $error("reset key did not reload defaults");

    init_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R17
        s_init_load |=> (del_ctrl_q == RST_CLOSED && sel_char_q == RST_SEL_CHAR))
        else $error("power-up load missing");

    rx_avail_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
        (master_request_enable && req_buffers_q[BIT_RX_AVAIL] && rx_not_empty)
        |=> service_request)
        else $error("receive data raised no request");

    tx_room_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
        (master_request_enable && req_buffers_q[BIT_TX_ROOM] && tx_not_full)
        |=> service_request)
        else $error("transmit room raised no request");

    manual_key_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
        (master_request_enable && req_events_q[BIT_MANUAL] && manual_sync)
        |=> service_request)
        else $error("manual key raised no request");

    autodisc_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
        (master_request_enable && req_events_q[BIT_AUTODISC] && autodisconnect)
        |=> service_request)
        else $error("autodisconnect raised no request");

    break_det_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
        (master_request_enable && req_events_q[BIT_BREAK] && break_sync)
        |=> service_request)
        else $error("break raised no request");

    err_other_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
        (master_request_enable && req_errors_q[BIT_DATA_ERR]
         && (framing_err || overrun_err || rx_overflow)) |=> service_request)
        else $error("line error raised no request");

    no_cond_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R19
        !any_cond |=> !service_request)
        else $error("request without any enabled condition");

    errors_wr_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
        (wr_errors && !load_defaults)
        |=> ({4'h0, req_errors_q} == ($past(reg_wdata) & {4'h0, USED_ERRORS})))
        else $error("request enable write not stored");

    delete_wr_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
        (wr_delete && !load_defaults)
        |=> ({4'h0, del_ctrl_q} == ($past(reg_wdata) & {4'h0, USED_DELETE})))
        else $error("delete control write not stored");

    rd_unused_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
        (rd_sel == REG_EVENTS) |=> !rd_data[3])
        else $error("unused bit read back set");
endmodule

// *** srcf_loop_model.sv ***
// loop controller model: register and selectable character writes
// assumes the bench calls its tasks; drives on the falling edge of core_clk
`timescale 1ns/1ps
module srcf_loop_model (
    input  wire logic       core_clk,
    output logic            reg_wr,
    output logic      [1:0] reg_sel,
    output logic      [7:0] reg_wdata,
    output logic            sel_char_wr,
    output logic      [7:0] sel_char_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_sel = 2'h0;
        reg_wdata = 8'h00;
        sel_char_wr = 1'b0;
        sel_char_wdata = 8'h00;
    end
    // listener 0 message then data byte, seen as one strobe
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_sel = s;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic wr_char(input logic [7:0] c);
        @(negedge core_clk);
        sel_char_wr = 1'b1;
        sel_char_wdata = c;
        @(negedge core_clk);
        sel_char_wr = 1'b0;
        sel_char_wdata = ~c;
    endtask
endmodule

// *** tb_service_request_and_char_filter.sv ***
// bench for srcf_core: request enables and receive character deletion
// assumes srcf_pkg and srcf_loop_model; inputs change on the falling edge
`timescale 1ns/1ps
module tb_service_request_and_char_filter;
    import srcf_pkg::*;
    localparam logic [3:0] USED [4] = '{USED_ERRORS, USED_BUFFERS, USED_EVENTS, USED_DELETE};
    logic        core_clk, reset_n, reset_key, sw_open, rx_valid;
    logic [1:0]  rd_sel, reg_sel;
    logic [7:0]  rx_char, reg_wdata, sel_wdata, rxbuf_wdata, d, c, selc;
    logic [3:0]  rd_data;
    logic [3:0]  regs [4];
    logic [10:0] cond;
    logic        reg_wr, sel_wr, rxbuf_wr, service_request;
    int          n_mismatch, n_checks, cyc;

    srcf_loop_model u_loop (.core_clk(core_clk), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .sel_char_wr(sel_wr), .sel_char_wdata(sel_wdata));
    srcf_core u_dut (.core_clk(core_clk), .reset_n(reset_n), .reset_key(reset_key),
        .request_switch_open(sw_open), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .sel_char_wr(sel_wr), .sel_char_wdata(sel_wdata),
        .rd_sel(rd_sel), .rd_data(rd_data), .parity_err(cond[0]), .framing_err(cond[1]),
        .overrun_err(cond[2]), .rx_overflow(cond[3]), .rx_full(cond[4]),
        .rx_not_empty(cond[5]), .tx_not_full(cond[6]), .tx_empty(cond[7]),
        .manual_request_key(cond[8]), .autodisconnect(cond[9]), .break_detect(cond[10]),
        .rx_char_valid(rx_valid), .rx_char(rx_char), .rxbuf_wr(rxbuf_wr),
        .rxbuf_wdata(rxbuf_wdata), .service_request(service_request));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_all();
        for (int r = 0; r < 4; r++) begin
            @(negedge core_clk);
            rd_sel = r[1:0];
            @(negedge core_clk);
            check({4'h0, rd_data}, {4'h0, regs[r]});
        end
    endtask
    function automatic logic exp_req();
        logic e;
        e = (regs[0][2] & (|cond[3:0])) | (regs[0][0] & cond[3]);
        e = e | (|(regs[1] & {cond[4], cond[5], cond[6], cond[7]}));
        e = e | (|(regs[2][2:0] & {cond[8], cond[9], cond[10]}));
        return regs[0][3] & e;
    endfunction
    task automatic send(input logic [7:0] ch);
        logic drop;
        drop = (regs[3][2] && ch == CHAR_DEL) || (regs[3][1] && ch == CHAR_NUL);
        drop = drop || (regs[3][0] && ch == selc);
        @(negedge core_clk);
        rx_valid = 1'b1;
        rx_char = ch;
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_char = ~ch;
        check({7'h0, rxbuf_wr}, {7'h0, !drop});
        if (!drop) check(rxbuf_wdata, ch);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // cut a hang short
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'h5e350e07));
        {reset_n, reset_key, sw_open, rx_valid, rd_sel, rx_char, cond} = '0;
        regs = '{4'h0, 4'h0, 4'h0, 4'h0};
        selc = RST_SEL_CHAR;
        repeat (16) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        rd_all();
        repeat (20) begin
            c = 8'($urandom_range(3));
            d = $urandom;
            u_loop.wr(c[1:0], d);
            regs[c[1:0]] = d[3:0] & USED[c[1:0]];
        end
        rd_all();
        repeat (60) begin
            for (int r = 0; r < 3; r++) begin
                d = $urandom;
                if (r == 0) d[3] = ($urandom_range(3) != 0);
                u_loop.wr(r[1:0], d);
                regs[r] = d[3:0] & USED[r];
            end
            cond = $urandom_range(1) ? 11'($urandom) : (11'h1 << $urandom_range(10));
            repeat (5) @(negedge core_clk);
            check({7'h0, service_request}, {7'h0, exp_req()});
        end
        cond = '0;
        repeat (8) begin
            d = $urandom;
            u_loop.wr(REG_DELETE, d);
            regs[3] = d[3:0] & USED[3];
            selc = $urandom;
            u_loop.wr_char(selc);
            repeat (10) begin
                case ($urandom_range(3))
                    0: c = CHAR_DEL;
                    1: c = CHAR_NUL;
                    2: c = selc;
                    default: c = $urandom;
                endcase
                send(c);
            end
        end
        sw_open = 1'b1;
        repeat (5) @(negedge core_clk);
        reset_key = 1'b1;
        repeat (4) @(negedge core_clk);
        reset_key = 1'b0;
        repeat (4) @(negedge core_clk);
        regs = '{RST_OPEN_ERRORS, RST_OPEN_BUFFER, RST_OPEN_EVENTS, RST_CLOSED};
        rd_all();
        sw_open = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        regs = '{4'h0, 4'h0, 4'h0, 4'h0};
        rd_all();
        sw_open = 1'b1;
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        regs = '{RST_OPEN_ERRORS, RST_OPEN_BUFFER, RST_OPEN_EVENTS, RST_CLOSED};
        rd_all();
        final_report();
    end
endmodule
